// ---- rtl/io_pin_monitor_pkg.sv ----
package io_pin_monitor_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned BOOT_TIME_S     = 30;
    localparam int unsigned BOOT_CYCLES     = BOOT_TIME_S * CLK_HZ;
    localparam int unsigned SAMPLE_WIN_MS   = 250;
    localparam int unsigned CONV_PER_SAMPLE = 20;
    localparam int unsigned CONV_CYCLES     = (SAMPLE_WIN_MS * (CLK_HZ / 1000)) / CONV_PER_SAMPLE;
    localparam int unsigned PULSE_MAX_HZ    = 140;
    localparam int unsigned DUTY_MIN_PCT    = 20;
    // Shortest legal pulse phase, rounded down so no legal pulse is rejected
    localparam int unsigned PULSE_MIN_CYC   = (CLK_HZ / PULSE_MAX_HZ) * DUTY_MIN_PCT / 100;
    localparam int unsigned FILT_CYCLES     = PULSE_MIN_CYC / 4;

    // ------------------------------------------------------------
    // Line layout
    // ------------------------------------------------------------
    localparam int unsigned NUM_LINES    = 5;
    localparam int unsigned LINE_PRIMARY = 0;  // Power connector line
    localparam int unsigned LINE_SER_A   = 3;  // Aux line shared with serial
    localparam int unsigned LINE_SER_B   = 4;  // Aux line shared with serial
    localparam int unsigned NUM_CHAN     = 5;  // Analog: 3 lines, supply, temperature
    localparam int unsigned CHAN_SUPPLY  = 3;
    localparam int unsigned CHAN_TEMP    = 4;
    localparam logic [4:0]  ANALOG_CAPABLE = 5'h07;
    localparam int unsigned ADC_W        = 12;
    localparam int unsigned CNT_W        = 16;

    // ------------------------------------------------------------
    // Significance thresholds in ADC codes
    // ------------------------------------------------------------
    localparam logic [11:0] THR_5V     = 12'h0a4;  // 200 mV at 5 V full scale
    localparam logic [11:0] THR_10V    = 12'h08f;  // 350 mV at 10 V full scale
    localparam logic [11:0] THR_SUPPLY = 12'h07b;  // 300 mV at 10 V full scale
    localparam logic [11:0] THR_TEMP   = 12'h00a;  // 1 degree in temperature codes

    // ------------------------------------------------------------
    // Per-line configuration
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_OFF     = 3'b000,
        MODE_DIGITAL = 3'b001,
        MODE_PULSE   = 3'b010,
        MODE_DRY     = 3'b011,
        MODE_ANALOG  = 3'b100,
        MODE_SINK    = 3'b101,
        MODE_OPEN    = 3'b110
    } line_mode_t;

    typedef struct packed {
        line_mode_t mode;
        logic       range10V;
        logic       standbyTrig;
        logic       outLevel;  // Output switch on for sink or open drain
    } line_cfg_t;

    localparam line_cfg_t CFG_DEFAULT = '{MODE_OFF, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic             valid;
        logic [2:0]       chan;
        logic [ADC_W-1:0] value;
    } adc_sample_t;

endpackage : io_pin_monitor_pkg

// ---- rtl/io_line_filter.sv ----
`timescale 1ns/10ps
module io_line_filter #(
    parameter int unsigned FILT = 8
) (
    // Clocking
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    // Line
    input  wire logic rawIn,
    output logic      levelOut,
    output logic      riseOut
);
    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic [15:0] cnt;
        logic        level;
        logic        rise;
    } filt_state_t;

    filt_state_t st_reg;
    filt_state_t st_next;

    // ------------------------------------------------------------
    // Two-stage synchroniser then a stability filter
    // ------------------------------------------------------------
    // Glitches shorter than FILT cycles never change the qualified level
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = rawIn;
        st_next.sync2 = st_reg.sync1;
        st_next.rise  = 1'b0;
        if (st_reg.sync2 == st_reg.level) begin
            st_next.cnt = 16'h0000;
        end else if (st_reg.cnt >= 16'(FILT)) begin
            st_next.level = st_reg.sync2;
            st_next.cnt   = 16'h0000;
            st_next.rise  = st_reg.sync2;
        end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    assign levelOut = st_reg.level;
    assign riseOut  = st_reg.rise & clkEn;
endmodule : io_line_filter

// ---- rtl/io_pin_monitor.sv ----
// What this block does
// - Serial enable kills input functions on shared lines
// - Standby trigger excludes sink and pull-up
// - Defaults during boot; settings after 30 s
// - Pulse counter handles 140 Hz, 20-80% duty
// - Standby suspends pulse counting
// - Standby suspends pull-up dry-contact inputs
// - Only power-connector input wakes from standby
// - Analog range per line: 5 V or 10 V
// - Average twenty conversions over 250 ms
// - Notify host on significant sample change
// - Thresholds 200 mV at 5 V, 350 mV at 10 V
// - Supply 300 mV, temperature 1 degree thresholds
// - Sink and open drain only on power line
// - Event on monitored input state change
`timescale 1ns/10ps
module io_pin_monitor #(
    parameter int unsigned BOOT_CYC = io_pin_monitor_pkg::BOOT_CYCLES,
    parameter int unsigned CONV_CYC = io_pin_monitor_pkg::CONV_CYCLES,
    parameter int unsigned FILT_CYC = io_pin_monitor_pkg::FILT_CYCLES
) (
    // Clocking
    input  wire logic                                clock,
    input  wire logic                                sys_rst,
    input  wire logic                                clkEn,
    // Configuration and router state
    input  wire io_pin_monitor_pkg::line_cfg_t [4:0] lineCfg,
    input  wire logic                                serialEn,
    input  wire logic                                standby,
    // Line pins
    input  wire logic [4:0]                          lineIn,
    output logic [4:0]                               pullUpEn,
    output logic                                     sinkOn,
    output logic                                     drainOe,
    output logic                                     drainOut,
    // Converter side
    input  wire io_pin_monitor_pkg::adc_sample_t     adcSample,
    output logic                                     adcStart,
    output logic [2:0]                               adcChan,
    // Results to host
    output logic [4:0]                               lineLevel,
    output logic [4:0][15:0]                         pulseCount,
    output logic [4:0][11:0]                         sampleVal,
    output logic [4:0]                               sampleNotify,
    output logic [4:0]                               lineEvent,
    output logic                                     wakeReq,
    output logic [4:0]                               cfgReject
);
    localparam int unsigned AW = io_pin_monitor_pkg::ADC_W;

    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_RUN  = 2'b01
    } run_state_t;

    typedef struct packed {
        run_state_t      phase;
        logic [31:0]     bootCnt;
        logic [31:0]     convCnt;
        logic [2:0]      chan;
        logic [4:0]      convIdx;
        logic [4:0][16:0] acc;
        logic [4:0]      rej;
        logic [4:0][11:0] sample;
        logic [4:0]      notify;
        logic [4:0][15:0] count;
        logic [4:0]      level;
        logic [4:0]      event_;
        logic [4:0]      pull;
        logic            sink;
        logic            drain;
        logic            wake;
        logic            start;
    } mon_state_t;

    mon_state_t st_reg;
    mon_state_t st_next;

    wire  [4:0]  qLevel;
    wire  [4:0]  qRise;
    wire  [4:0]  fnEn;
    wire  [4:0]  reject;

    // ------------------------------------------------------------
    // Per-line qualification, gating and configuration checks
    // ------------------------------------------------------------
    // Every line gets its own synchroniser and stability filter; the filter
    // length is short against the narrowest legal pulse phase, so rated
    // pulses always pass while contact bounce is swallowed
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_line
            io_line_filter #(
                .FILT     (FILT_CYC)
            ) u_io_line_filter (
                .clock    (clock),
                .sys_rst  (sys_rst),
                .clkEn    (clkEn),
                .rawIn    (lineIn[gi]),
                .levelOut (qLevel[gi]),
                .riseOut  (qRise[gi])
            );

            // Serial use of a shared line takes every input function away
            assign fnEn[gi] = !(serialEn && ((gi == io_pin_monitor_pkg::LINE_SER_A) ||
                                             (gi == io_pin_monitor_pkg::LINE_SER_B)));

            // Refused settings leave the line idle instead of half applied
            assign reject[gi] =
                (lineCfg[gi].standbyTrig &&
                 ((lineCfg[gi].mode == io_pin_monitor_pkg::MODE_SINK) ||
                  (lineCfg[gi].mode == io_pin_monitor_pkg::MODE_DRY))) ||
                ((gi != io_pin_monitor_pkg::LINE_PRIMARY) &&
                 ((lineCfg[gi].mode == io_pin_monitor_pkg::MODE_SINK) ||
                  (lineCfg[gi].mode == io_pin_monitor_pkg::MODE_OPEN))) ||
                (!io_pin_monitor_pkg::ANALOG_CAPABLE[gi] &&
                 (lineCfg[gi].mode == io_pin_monitor_pkg::MODE_ANALOG));
        end
    endgenerate

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Nothing the user configured reaches a pin until boot is over; the
    // reset value of every output field is the safe default
    always_comb begin
        logic [16:0]   avgWide;
        logic [AW-1:0] avg;
        logic [AW-1:0] diff;
        logic [AW-1:0] thr;
        logic [2:0]    nextChan;
        logic          chanOn;
        logic          running;
        avgWide  = 17'h00000;
        avg      = '0;
        diff     = '0;
        thr      = '0;
        nextChan = 3'h0;
        chanOn   = 1'b0;
        running  = (st_reg.phase == ST_RUN);
        st_next  = st_reg;

        // Boot timer, then settings go live
        if (st_reg.phase == ST_BOOT) begin
            if (st_reg.bootCnt >= 32'(BOOT_CYC - 1)) begin
                st_next.phase = ST_RUN;
            end else begin
                st_next.bootCnt = st_reg.bootCnt + 32'h00000001;
            end
        end

        // Per-line input functions
        for (int i = 0; i < 5; i++) begin
            st_next.event_[i] = 1'b0;
            // Pull-up only for dry contacts, dropped in standby
            st_next.pull[i] = running && fnEn[i] && !reject[i] && !standby &&
                              (lineCfg[i].mode == io_pin_monitor_pkg::MODE_DRY);
            // Counter frozen in standby and on refused or serial lines
            if (running && fnEn[i] && !reject[i] && !standby && qRise[i] &&
                (lineCfg[i].mode == io_pin_monitor_pkg::MODE_PULSE)) begin
                st_next.count[i] = st_reg.count[i] + 16'h0001;
            end
            // Monitored level and its change event
            if (running && fnEn[i] && !reject[i] &&
                ((lineCfg[i].mode == io_pin_monitor_pkg::MODE_DIGITAL) ||
                 (lineCfg[i].mode == io_pin_monitor_pkg::MODE_PULSE) ||
                 ((lineCfg[i].mode == io_pin_monitor_pkg::MODE_DRY) && !standby))) begin
                st_next.level[i]  = qLevel[i];
                st_next.event_[i] = (qLevel[i] != st_reg.level[i]);
            end
        end
        st_next.rej = reject;

        // Output switches exist on the power connector line only
        st_next.sink = running && !reject[io_pin_monitor_pkg::LINE_PRIMARY] &&
                       (lineCfg[io_pin_monitor_pkg::LINE_PRIMARY].mode == io_pin_monitor_pkg::MODE_SINK) &&
                       lineCfg[io_pin_monitor_pkg::LINE_PRIMARY].outLevel;
        st_next.drain = running && !reject[io_pin_monitor_pkg::LINE_PRIMARY] &&
                        (lineCfg[io_pin_monitor_pkg::LINE_PRIMARY].mode == io_pin_monitor_pkg::MODE_OPEN) &&
                        lineCfg[io_pin_monitor_pkg::LINE_PRIMARY].outLevel;

        // Wake comes from the power connector digital input alone
        st_next.wake = running && standby &&
                       (lineCfg[io_pin_monitor_pkg::LINE_PRIMARY].mode == io_pin_monitor_pkg::MODE_DIGITAL) &&
                       (qLevel[io_pin_monitor_pkg::LINE_PRIMARY] !=
                        st_reg.level[io_pin_monitor_pkg::LINE_PRIMARY]);

        // ------------------------------------------------------------
        // Analog sampler: one channel at a time, twenty conversions each
        // ------------------------------------------------------------
        st_next.start  = 1'b0;
        st_next.notify = 5'h00;
        if (st_reg.chan >= 3'(io_pin_monitor_pkg::NUM_CHAN - 1)) begin
            nextChan = 3'h0;
        end else begin
            nextChan = st_reg.chan + 3'h1;
        end
        // Supply and temperature are always watched, lines only when analog
        chanOn = (st_reg.chan >= 3'(io_pin_monitor_pkg::CHAN_SUPPLY)) ||
                 ((lineCfg[st_reg.chan].mode == io_pin_monitor_pkg::MODE_ANALOG) &&
                  fnEn[st_reg.chan] && !reject[st_reg.chan]);
        if (st_reg.chan == 3'(io_pin_monitor_pkg::CHAN_TEMP)) begin
            thr = io_pin_monitor_pkg::THR_TEMP;
        end else if (st_reg.chan == 3'(io_pin_monitor_pkg::CHAN_SUPPLY)) begin
            thr = io_pin_monitor_pkg::THR_SUPPLY;
        end else if (lineCfg[st_reg.chan].range10V) begin
            thr = io_pin_monitor_pkg::THR_10V;
        end else begin
            thr = io_pin_monitor_pkg::THR_5V;
        end
        // Average includes the conversion arriving now; the sum of twenty
        // full-scale codes still fits seventeen bits
        avgWide = (st_reg.acc[st_reg.chan] + 17'(adcSample.value)) /
                  17'(io_pin_monitor_pkg::CONV_PER_SAMPLE);
        avg     = avgWide[AW-1:0];
        if (avg >= st_reg.sample[st_reg.chan]) begin
            diff = avg - st_reg.sample[st_reg.chan];
        end else begin
            diff = st_reg.sample[st_reg.chan] - avg;
        end

        if (running && !chanOn) begin
            // Skip an idle channel at once so the others keep their pace
            st_next.chan               = nextChan;
            st_next.convIdx            = 5'h00;
            st_next.acc[st_reg.chan]   = 17'h00000;
        end else if (running) begin
            // Conversion pacing
            if (st_reg.convCnt >= 32'(CONV_CYC - 1)) begin
                st_next.convCnt = 32'h00000000;
                st_next.start   = 1'b1;
            end else begin
                st_next.convCnt = st_reg.convCnt + 32'h00000001;
            end
            // A result for another channel is stale and ignored
            if (adcSample.valid && (adcSample.chan == st_reg.chan)) begin
                if (st_reg.convIdx >= 5'(io_pin_monitor_pkg::CONV_PER_SAMPLE - 1)) begin
                    st_next.sample[st_reg.chan] = avg;
                    st_next.notify[st_reg.chan] = (diff >= thr);
                    st_next.acc[st_reg.chan]    = 17'h00000;
                    st_next.convIdx             = 5'h00;
                    st_next.chan                = nextChan;
                end else begin
                    st_next.acc[st_reg.chan] = st_reg.acc[st_reg.chan] + 17'(adcSample.value);
                    st_next.convIdx          = st_reg.convIdx + 5'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset returns to boot with every switch open and every pull-up off
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops, except drainOut tied low
    assign pullUpEn     = st_reg.pull;
    assign sinkOn       = st_reg.sink;
    assign drainOe      = st_reg.drain;
    assign drainOut     = 1'b0; // Open drain only ever pulls low
    assign adcStart     = st_reg.start;
    assign adcChan      = st_reg.chan;
    assign lineLevel    = st_reg.level;
    assign pulseCount   = st_reg.count;
    assign sampleVal    = st_reg.sample;
    assign sampleNotify = st_reg.notify;
    assign lineEvent    = st_reg.event_;
    assign wakeReq      = st_reg.wake;
    assign cfgReject    = st_reg.rej;
endmodule : io_pin_monitor

// ---- sim/io_pin_monitor_properties.sv ----
`timescale 1ns/10ps
module io_pin_monitor_properties #(
    parameter int unsigned BOOT_CYC = 20
) (
    input wire logic                                clock,
    input wire logic                                sys_rst,
    input wire io_pin_monitor_pkg::line_cfg_t [4:0] lineCfg,
    input wire logic                                serialEn,
    input wire logic                                standby,
    input wire logic [4:0]                          pullUpEn,
    input wire logic                                sinkOn,
    input wire logic                                drainOe,
    input wire logic [4:0][15:0]                    pulseCount
);
    // Cycles since reset; saturates so it never wraps back into boot
    int unsigned age;
    always_ff @(posedge clock) age <= sys_rst ? 0 : ((age < BOOT_CYC) ? age + 1 : age);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_boot; age < BOOT_CYC - 1 |-> !sinkOn && !drainOe && pullUpEn == '0; endproperty
    a_boot: assert property (p_boot) else $error("output active during boot");
    property p_ser; serialEn [*4] |-> $stable(pulseCount[4:3]) && pullUpEn[4:3] == '0; endproperty
    a_ser: assert property (p_ser) else $error("shared line active with serial on");
    property p_sbyCnt; standby [*4] |-> $stable(pulseCount); endproperty
    a_sbyCnt: assert property (p_sbyCnt) else $error("count moved in standby");
    property p_sbyPull; standby [*4] |-> pullUpEn == '0; endproperty
    a_sbyPull: assert property (p_sbyPull) else $error("pull-up on in standby");
    property p_step; $changed(pulseCount[1]) |-> pulseCount[1] == $past(pulseCount[1]) + 16'h1; endproperty
    a_step: assert property (p_step) else $error("count step not one");
    property p_trig; lineCfg[0].standbyTrig [*3] |-> !sinkOn && !pullUpEn[0]; endproperty
    a_trig: assert property (p_trig) else $error("sink or pull-up with standby trigger");
    property p_sink; (lineCfg[0].mode != io_pin_monitor_pkg::MODE_SINK) [*3] |-> !sinkOn; endproperty
    a_sink: assert property (p_sink) else $error("sink on without sink mode");
    property p_drain; (lineCfg[0].mode != io_pin_monitor_pkg::MODE_OPEN) [*3] |-> !drainOe; endproperty
    a_drain: assert property (p_drain) else $error("drain on without drain mode");
    c_sink: cover property (sinkOn);
    c_pull: cover property (pullUpEn[0]);
    c_cnt: cover property ($changed(pulseCount[1]));
endmodule : io_pin_monitor_properties
bind io_pin_monitor io_pin_monitor_properties #(.BOOT_CYC(BOOT_CYC)) u_io_pin_monitor_properties (
    .clock, .sys_rst, .lineCfg, .serialEn, .standby, .pullUpEn, .sinkOn, .drainOe, .pulseCount);

// ---- sim/io_line_partner.sv ----
`timescale 1ns/10ps
module io_line_partner #(
    parameter int unsigned HALF = 8
) (
    input  wire logic       clock,
    output logic      [4:0] lineIn
);
    initial lineIn = '0;
    // Half duty square pulses, far faster than the rated top rate to stress the counter
    task automatic send(input logic [4:0] mask, input int n);
        repeat (n) begin
            repeat (HALF) @(negedge clock);
            lineIn = mask;
            repeat (HALF) @(negedge clock);
            lineIn = '0;
        end
    endtask : send
    // Hold a static level, as a closed or open switch would
    task automatic hold(input logic [4:0] mask);
        @(negedge clock);
        lineIn = mask;
    endtask : hold
endmodule : io_line_partner

// ---- sim/io_pin_monitor_tb.sv ----
`timescale 1ns/10ps
module io_pin_monitor_tb;
    localparam int unsigned BOOT = 20;
    logic                                clock = 0;
    logic                                sys_rst = 1;
    logic                                serialEn = 0;
    logic                                standby = 0;
    io_pin_monitor_pkg::line_cfg_t [4:0] lineCfg = '0;
    logic [4:0]                          lineIn;
    logic [4:0]                          pullUpEn;
    logic                                sinkOn;
    logic [4:0][15:0]                    pulseCount;
    logic [4:0]                          lineLevel;
    logic [4:0]                          sampleNotify;
    logic [4:0]                          lineEvent;
    logic [4:0]                          cfgReject;
    logic                                wakeReq;
    logic                                drainOe;
    logic                                adcStart;
    logic [2:0]                          adcChan;
    logic [4:0][11:0]                    sampleVal;
    logic [11:0]                         adcVal = 12'h000;
    io_pin_monitor_pkg::adc_sample_t     adcSample = '0;
    int                                  error_cnt = 0;
    int                                  compares = 0;
    // Free running clock, 40 ns period
    initial forever #20 clock = ~clock;
    io_line_partner u_io_line_partner (.clock(clock), .lineIn(lineIn));
    io_pin_monitor #(.BOOT_CYC(BOOT), .CONV_CYC(4), .FILT_CYC(2)) u_io_pin_monitor (
        .clock(clock), .sys_rst(sys_rst), .clkEn(1'b1), .lineCfg(lineCfg), .serialEn(serialEn),
        .standby(standby), .lineIn(lineIn), .pullUpEn(pullUpEn), .sinkOn(sinkOn), .drainOe(drainOe),
        .drainOut(), .adcSample(adcSample), .adcStart(adcStart), .adcChan(adcChan), .lineLevel(lineLevel),
        .pulseCount(pulseCount), .sampleVal(sampleVal), .sampleNotify(sampleNotify), .lineEvent(lineEvent),
        .wakeReq(wakeReq), .cfgReject(cfgReject));
    // Converter model: answers each start one cycle later on the asked channel
    always @(negedge clock) adcSample = '{adcStart, adcChan, adcVal};
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic cfg(input int i, input io_pin_monitor_pkg::line_mode_t m, input logic trig);
        lineCfg[i] = '{m, 1'b0, trig, 1'b1};
    endtask : cfg
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    // Pull-up held off through boot, applied once boot is over
    task automatic t_boot;
        cfg(0, io_pin_monitor_pkg::MODE_DRY, 1'b0);
        tick(BOOT - 6);
        check("pullUpEn", 16'h0, 16'(pullUpEn));
        tick(20);
        check("pullUpEn", 16'h1, 16'(pullUpEn));
        $display("boot done");
    endtask : t_boot
    // Counting on line 1 while serial use blocks line 3, then blocked by standby
    task automatic t_count;
        cfg(1, io_pin_monitor_pkg::MODE_PULSE, 1'b0);
        cfg(3, io_pin_monitor_pkg::MODE_PULSE, 1'b0);
        serialEn = 1;
        u_io_line_partner.send(5'h0a, 3);
        tick(10);
        check("count1", 16'h3, pulseCount[1]);
        check("count3", 16'h0, pulseCount[3]);
        serialEn = 0;
        standby = 1;
        u_io_line_partner.send(5'h02, 2);
        tick(10);
        check("count1", 16'h3, pulseCount[1]);
        check("pullUpEn", 16'h0, 16'(pullUpEn));
        standby = 0;
        tick(10);
        check("pullUpEn", 16'h1, 16'(pullUpEn));
        $display("count done");
    endtask : t_count
    // Sink refused with standby trigger, granted without it
    task automatic t_sink;
        cfg(0, io_pin_monitor_pkg::MODE_SINK, 1'b1);
        tick(10);
        check("sinkOn", 16'h0, 16'(sinkOn));
        cfg(0, io_pin_monitor_pkg::MODE_SINK, 1'b0);
        tick(10);
        check("sinkOn", 16'h1, 16'(sinkOn));
        $display("sink done");
    endtask : t_sink
    // Level change raises an event; only the power line wakes; bad output modes refused
    task automatic t_event;
        logic hit;
        cfg(2, io_pin_monitor_pkg::MODE_DIGITAL, 1'b0);
        tick(4);
        hit = 1'b0;
        u_io_line_partner.hold(5'h04);
        repeat (20) begin
            tick(1);
            hit |= lineEvent[2];
        end
        check("lineEvent", 16'h1, 16'(hit));
        check("lineLevel", 16'h4, 16'(lineLevel));
        standby = 1;
        cfg(0, io_pin_monitor_pkg::MODE_DIGITAL, 1'b0);
        tick(4);
        hit = 1'b0;
        u_io_line_partner.hold(5'h00);
        repeat (20) begin
            tick(1);
            hit |= wakeReq;
        end
        check("wakeReq aux", 16'h0, 16'(hit));
        hit = 1'b0;
        u_io_line_partner.hold(5'h01);
        repeat (20) begin
            tick(1);
            hit |= wakeReq;
        end
        check("wakeReq", 16'h1, 16'(hit));
        standby = 0;
        cfg(1, io_pin_monitor_pkg::MODE_OPEN, 1'b0);
        tick(4);
        check("cfgReject", 16'h2, 16'(cfgReject));
        check("drainOe", 16'h0, 16'(drainOe));
        $display("event done");
    endtask : t_event
    // Large step notifies; small drift only updates the value the host polls
    task automatic t_analog;
        logic hit;
        adcVal = 12'h200;
        cfg(0, io_pin_monitor_pkg::MODE_ANALOG, 1'b0);
        hit = 1'b0;
        repeat (400) begin
            tick(1);
            hit |= sampleNotify[0];
        end
        check("sampleNotify", 16'h1, 16'(hit));
        check("sampleVal", 16'h200, 16'(sampleVal[0]));
        adcVal = 12'h250;
        hit = 1'b0;
        repeat (800) begin
            tick(1);
            hit |= sampleNotify[0];
        end
        check("sampleNotify small", 16'h0, 16'(hit));
        check("sampleVal", 16'h250, 16'(sampleVal[0]));
        $display("analog done");
    endtask : t_analog
    // Main sequence; every wait is a fixed count
    initial begin
        tick(2);
        sys_rst = 0;
        t_boot();
        t_count();
        t_sink();
        t_event();
        t_analog();
        stop_test();
    end
endmodule : io_pin_monitor_tb
